/* usifc_top.sv */
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module usifc_top
    import usifc_pkg::*;
#(
    parameter int LVL_W = 7                        // RX FIFO level width
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_psel,
    input  wire logic             i_penable,
    input  wire logic             i_pwrite,
    input  wire logic [7:0]       i_paddr,
    input  wire logic [31:0]      i_pwdata,
    output logic      [31:0]      o_prdata,
    output logic                  o_pready,
    output logic                  o_pslverr,
    input  wire logic             i_cts_n,
    input  wire logic             i_dsr_n,
    input  wire logic             i_ri_n,
    input  wire logic             i_cd_n,
    output logic                  o_rts_n,
    output logic                  o_dtr_n,
    input  wire logic             i_line_err,
    input  wire logic             i_rx_timeout,
    input  wire logic             i_rx_ready,
    input  wire logic             i_tx_empty,
    input  wire logic             i_rx_valid,
    input  wire logic [7:0]       i_rx_char,
    input  wire logic             i_xoff_seen,
    input  wire logic [LVL_W-1:0] i_rx_level,
    output logic                  o_irq,
    output logic                  o_tx_halt,
    output logic                  o_sleep_en,
    output logic                  o_loopback,
    output logic      [3:0]       o_sw_flow_sel,
    output logic                  o_xon_any,
    output logic                  o_fifo_en
);

//////////////////////////////////////////////////////////////////////////////
// Declarations
logic [7:0] ier_reg;        // Interrupt source enables
logic [7:0] efr_reg;        // Enhanced feature control
logic [7:0] mcr_reg;        // Modem line control
logic [7:0] fcr_reg;        // FIFO control copy
logic [7:0] tcr_reg;        // Halt/restore thresholds
logic [7:0] xoff2_reg;      // Special character
logic [3:0] delta_reg;      // Sticky modem deltas
logic [3:0] sy1_reg;        // Sync stage one, only read by stage two
logic [3:0] sy2_reg;        // Sync stage two {cd,ri,dsr,cts}, active low
logic [3:0] src_prev_reg;   // Previous active-high sources
logic       xoff_flag_reg;  // Xoff or special char seen
logic       flow_flag_reg;  // CTS/RTS went inactive
logic       rts_n_reg;
logic [3:0] rd_delta_reg;   // Deltas shown by the read in flight
logic [1:0] rd_flag_reg;    // Flags shown by the read in flight
logic       rd_msr_reg;     // Read in flight targets modem state
logic       rd_id_reg;      // Read in flight targets ident
logic [3:0] src;            // Active-high {cd,ri,dsr,cts}
logic [7:0] msr_val;
logic [7:0] ident_val;
logic [5:0] code;
logic       any_pend;
logic       setup;          // APB setup phase
logic       wr_acc;         // APB write completes
logic       rd_acc;         // APB read completes
logic       unlk;           // Enhanced write enable
logic       rts_n_next;
logic [LVL_W-1:0] halt_lvl;
logic [LVL_W-1:0] rest_lvl;
logic       sp_hit;
logic       flow_evt;
logic       mapped;

//////////////////////////////////////////////////////////////////////////////
// Bus phase decode
assign setup  = i_psel & ~i_penable;
assign wr_acc = i_psel & i_penable & i_pwrite;
assign rd_acc = i_psel & i_penable & ~i_pwrite;
assign unlk   = efr_reg[EFR_WEN];

// Mapped window check
always_comb begin
    unique case (i_paddr)
        OFS_MSR_LINE, OFS_IER_SRC, OFS_IDENT, OFS_EFR,
        OFS_MCR, OFS_FCR, OFS_TCR, OFS_XOFF2: mapped = 1'b1;
        default: mapped = 1'b0;            // Unmapped answers with error
    endcase
end

//////////////////////////////////////////////////////////////////////////////
// Modem input synchronisers, two flops
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        sy1_reg <= {4{RST_PIN_N}};
        sy2_reg <= {4{RST_PIN_N}};
    end else begin
        sy1_reg <= {i_cd_n, i_ri_n, i_dsr_n, i_cts_n};
        sy2_reg <= sy1_reg;
    end
end

// Source select: pins or loopback control bits
always_comb begin
    if (mcr_reg[MCR_LOOP]) begin
        src = {mcr_reg[3], mcr_reg[2], mcr_reg[0], mcr_reg[1]};
    end else begin
        src = ~sy2_reg;
    end
end

// Previous source levels for change detection
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        src_prev_reg <= 4'h0;
    end else begin
        src_prev_reg <= src;
    end
end

// Sticky deltas; a new change beats the read clear
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        delta_reg <= 4'h0;
    end else begin
        for (int k = 0; k < 4; k++) begin
            if ((k == 2) ? (src[k] & ~src_prev_reg[k])
                         : (src[k] ^ src_prev_reg[k])) begin
                delta_reg[k] <= 1'b1;
            end else if (rd_acc && rd_msr_reg && rd_delta_reg[k]) begin
                delta_reg[k] <= 1'b0;
            end
        end
    end
end

assign msr_val = {src, delta_reg};

//////////////////////////////////////////////////////////////////////////////
// Control register writes
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        ier_reg <= RST_REG8;
    end else if (wr_acc && i_paddr == OFS_IER_SRC) begin
        ier_reg[3:0] <= i_pwdata[3:0];
        if (unlk) begin
            ier_reg[7:4] <= i_pwdata[7:4];
        end
    end
end

// Feature register has no lock of its own
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        efr_reg <= RST_REG8;
    end else if (wr_acc && i_paddr == OFS_EFR) begin
        efr_reg <= i_pwdata[7:0];
    end
end

// Modem control, top three bits locked
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        mcr_reg <= RST_REG8;
    end else if (wr_acc && i_paddr == OFS_MCR) begin
        mcr_reg[4:0] <= i_pwdata[4:0];
        if (unlk) begin
            mcr_reg[7:5] <= i_pwdata[7:5];
        end
    end
end

// FIFO control copy, bits 5:4 locked
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        fcr_reg <= RST_REG8;
    end else if (wr_acc && i_paddr == OFS_FCR) begin
        fcr_reg[3:0] <= i_pwdata[3:0];
        fcr_reg[7:6] <= i_pwdata[7:6];
        if (unlk) begin
            fcr_reg[5:4] <= i_pwdata[5:4];
        end
    end
end

// Thresholds need unlock plus access bit
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        tcr_reg <= RST_REG8;
    end else if (wr_acc && i_paddr == OFS_TCR && unlk && mcr_reg[MCR_TLRACC]) begin
        tcr_reg <= i_pwdata[7:0];
    end
end

// Special character value
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        xoff2_reg <= RST_REG8;
    end else if (wr_acc && i_paddr == OFS_XOFF2) begin
        xoff2_reg <= i_pwdata[7:0];
    end
end

//////////////////////////////////////////////////////////////////////////////
// Flow control
// Nibble times four gives bytes 0..60
assign halt_lvl = LVL_W'({tcr_reg[3:0], 2'b00});
assign rest_lvl = LVL_W'({tcr_reg[7:4], 2'b00});

// Auto-RTS holds between the two levels; no check that halt > restore
always_comb begin
    if (!efr_reg[EFR_ARTS]) begin
        rts_n_next = ~mcr_reg[1];
    end else if (i_rx_level >= halt_lvl) begin
        rts_n_next = 1'b1;
    end else if (i_rx_level <= rest_lvl) begin
        rts_n_next = 1'b0;
    end else begin
        rts_n_next = rts_n_reg;
    end
end

// Modem output pins
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        rts_n_reg <= RST_PIN_N;
        o_dtr_n   <= RST_PIN_N;
    end else begin
        rts_n_reg <= rts_n_next;
        o_dtr_n   <= ~mcr_reg[0];
    end
end
assign o_rts_n = rts_n_reg;

// Transmitter halt while CTS inactive
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        o_tx_halt <= 1'b0;
    end else begin
        o_tx_halt <= efr_reg[EFR_ACTS] & ~src[0];
    end
end

//////////////////////////////////////////////////////////////////////////////
// Event flags; set beats ident read clear
assign sp_hit   = efr_reg[EFR_SPCHR] & i_rx_valid & (i_rx_char == xoff2_reg);
// Active to inactive on CTS or RTS
assign flow_evt = (ier_reg[7] & src_prev_reg[0] & ~src[0])
                | (ier_reg[6] & ~rts_n_reg & rts_n_next);

always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        xoff_flag_reg <= 1'b0;
    end else if (sp_hit || i_xoff_seen) begin
        xoff_flag_reg <= 1'b1;
    end else if (rd_acc && rd_id_reg && rd_flag_reg[0]) begin
        xoff_flag_reg <= 1'b0;
    end
end

always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        flow_flag_reg <= 1'b0;
    end else if (flow_evt) begin
        flow_flag_reg <= 1'b1;
    end else if (rd_acc && rd_id_reg && rd_flag_reg[1]) begin
        flow_flag_reg <= 1'b0;
    end
end

//////////////////////////////////////////////////////////////////////////////
// Priority encoder, highest source first
always_comb begin
    any_pend = 1'b1;
    if (ier_reg[2] && i_line_err) begin
        code = ID_LINE;
    end else if (ier_reg[0] && i_rx_timeout) begin
        code = ID_TIMEOUT;
    end else if (ier_reg[0] && i_rx_ready) begin
        code = ID_RHR;
    end else if (ier_reg[1] && i_tx_empty) begin
        code = ID_THR;
    end else if (ier_reg[3] && |delta_reg) begin
        code = ID_MODEM;
    end else if (ier_reg[5] && xoff_flag_reg) begin
        code = ID_XOFF;
    end else if (flow_flag_reg) begin
        code = ID_FLOW;
    end else begin
        any_pend = 1'b0;
        code     = ID_NONE;
    end
end

// Bits 7:6 mirror FIFO enable; bits 5 and 4 flag events
assign ident_val = {{2{fcr_reg[0]}}, code};

// Interrupt pin from a flop
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        o_irq <= 1'b0;
    end else begin
        o_irq <= any_pend;
    end
end

//////////////////////////////////////////////////////////////////////////////
// APB read path: data latched in setup, so pready can stay high
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        o_prdata     <= 32'h0000_0000;
        o_pslverr    <= 1'b0;
        rd_delta_reg <= 4'h0;
        rd_flag_reg  <= 2'h0;
        rd_msr_reg   <= 1'b0;
        rd_id_reg    <= 1'b0;
    end else if (setup) begin
        o_pslverr    <= ~mapped;
        rd_delta_reg <= delta_reg;
        rd_flag_reg  <= code[5:4];
        rd_msr_reg   <= ~i_pwrite & (i_paddr == OFS_MSR_LINE);
        rd_id_reg    <= ~i_pwrite & (i_paddr == OFS_IDENT);
        unique case (i_paddr)
            OFS_MSR_LINE: o_prdata <= {24'h00_0000, msr_val};
            OFS_IER_SRC:  o_prdata <= {24'h00_0000, ier_reg};
            OFS_IDENT:    o_prdata <= {24'h00_0000, ident_val};
            OFS_EFR:      o_prdata <= {24'h00_0000, efr_reg};
            OFS_MCR:      o_prdata <= {24'h00_0000, mcr_reg};
            OFS_FCR:      o_prdata <= {24'h00_0000, fcr_reg};
            OFS_TCR:      o_prdata <= {24'h00_0000, tcr_reg};
            OFS_XOFF2:    o_prdata <= {24'h00_0000, xoff2_reg};
            default:      o_prdata <= 32'h0000_0000;
        endcase
    end
end

// Zero wait states
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        o_pready <= 1'b0;
    end else begin
        o_pready <= 1'b1;
    end
end

// Plain register views
assign o_sleep_en    = ier_reg[4];
assign o_loopback    = mcr_reg[MCR_LOOP];
assign o_sw_flow_sel = efr_reg[3:0];
assign o_xon_any     = mcr_reg[5];
assign o_fifo_en     = fcr_reg[0];

//////////////////////////////////////////////////////////////////////////////
// Checks
AST_CHG_SETS: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (src[0] != src_prev_reg[0]) |=> delta_reg[0])
    else $error("cts change not recorded");

AST_RI_EDGE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(delta_reg[2]) |-> $past(src[2] & ~src_prev_reg[2]))
    else $error("ri delta without rising edge");

AST_PIN_LEVEL: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !mcr_reg[MCR_LOOP] |-> msr_val[7:4] == ~sy2_reg)
    else $error("level bits not inverted pins");

AST_LOOP_LEVEL: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    mcr_reg[MCR_LOOP] |-> msr_val[5:4] == {mcr_reg[0], mcr_reg[1]})
    else $error("loopback levels wrong");

AST_IER_LOCK: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (wr_acc && i_paddr == OFS_IER_SRC && !unlk) |=> $stable(ier_reg[7:4]))
    else $error("locked enable bits changed");

AST_IRQ_FOLLOW: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    any_pend ##1 any_pend |-> o_irq)
    else $error("irq not raised for pending source");

AST_IDLE_IDENT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !any_pend |-> ident_val[0] ##1 (!o_irq || any_pend))
    else $error("idle ident or irq wrong");

AST_MIRROR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ident_val[7:6] == {2{fcr_reg[0]}})
    else $error("ident top bits not mirrored");

AST_TX_HALT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (efr_reg[EFR_ACTS] && sy2_reg[0] && !mcr_reg[MCR_LOOP]) |=> o_tx_halt)
    else $error("transmit not halted");

AST_RTS_HALT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (efr_reg[EFR_ARTS] && i_rx_level >= halt_lvl) |=> o_rts_n)
    else $error("rts not raised at halt level");

AST_SPCHR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    sp_hit |=> xoff_flag_reg)
    else $error("special char not flagged");

endmodule : usifc_top

/* usifc_pkg.sv */
package usifc_pkg;
    // Register byte offsets on the APB window
    localparam logic [7:0] OFS_MSR_LINE = 8'h00;   // modem_line_state
    localparam logic [7:0] OFS_IER_SRC  = 8'h04;   // interrupt_source_enable
    localparam logic [7:0] OFS_IDENT    = 8'h08;   // interrupt_source_ident
    localparam logic [7:0] OFS_EFR      = 8'h0C;   // enhanced_feature_ctrl
    localparam logic [7:0] OFS_MCR      = 8'h10;   // modem_line_control
    localparam logic [7:0] OFS_FCR      = 8'h14;   // fifo_control
    localparam logic [7:0] OFS_TCR      = 8'h18;   // flow_threshold_levels
    localparam logic [7:0] OFS_XOFF2    = 8'h1C;   // second Xoff character
    // Values after reset
    localparam logic [7:0] RST_REG8     = 8'h00;
    localparam logic       RST_PIN_N    = 1'h1;    // Modem lines idle high
    // Identification codes, bits 5:0
    localparam logic [5:0] ID_LINE      = 6'h06;
    localparam logic [5:0] ID_TIMEOUT   = 6'h0C;
    localparam logic [5:0] ID_RHR       = 6'h04;
    localparam logic [5:0] ID_THR       = 6'h02;
    localparam logic [5:0] ID_MODEM     = 6'h00;
    localparam logic [5:0] ID_XOFF      = 6'h10;
    localparam logic [5:0] ID_FLOW      = 6'h20;
    localparam logic [5:0] ID_NONE      = 6'h01;
    // Field positions
    localparam int EFR_WEN    = 4;
    localparam int EFR_SPCHR  = 5;
    localparam int EFR_ARTS   = 6;
    localparam int EFR_ACTS   = 7;
    localparam int MCR_LOOP   = 4;
    localparam int MCR_TLRACC = 6;
endpackage : usifc_pkg

/* usifc_peer.sv */
//////////////////////////////////////////////////////////////////////////////
// Behavioural modem peer: drives the four active-low status lines
module usifc_peer (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic [3:0] i_assert,     // Asserted lines: CD, RI, DSR, CTS
    output logic            o_cts_n,      // Clear to send, active low
    output logic            o_dsr_n,      // Data set ready, active low
    output logic            o_ri_n,       // Ring indicator, active low
    output logic            o_cd_n        // Carrier detect, active low
);
    timeunit 1ns;
    timeprecision 1ns;

    //////////////////////////////////////////////////////////////////////////
    // Lines change only after a clock edge, idle high in reset
    // CTS high pauses the far transmitter, so deassert means pause
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {o_cd_n, o_ri_n, o_dsr_n, o_cts_n} <= 4'hF;
        end else begin
            {o_cd_n, o_ri_n, o_dsr_n, o_cts_n} <= ~i_assert;
        end
    end
endmodule : usifc_peer

/* tb.sv */
//////////////////////////////////////////////////////////////////////////////
// Register-level regression of the status and flow control block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import usifc_pkg::*;

    logic        core_clk = 1'b0;   // 10 MHz clock
    logic        rst_n    = 1'b0;   // Active low reset
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  line_cmd = 4'h0;   // Peer line assertions
    logic        cts_n, dsr_n, ri_n, cd_n, rts_n, dtr_n;
    logic [3:0]  srcs     = 4'h0;   // Line error, timeout, rx ready, tx empty
    logic        rx_valid = 1'b0;
    logic [7:0]  rx_char  = 8'h00;
    logic        xoff_seen = 1'b0;
    logic [6:0]  rx_level = 7'h00;
    logic        irq, tx_halt, sleep_en, loopback, xon_any, fifo_en;
    logic [3:0]  sw_flow_sel;
    int          err_total = 0;
    int          cmp_count = 0;
    int          tick      = 0;
    logic [31:0] d;
    logic        e;
    logic        ri0;

    always #50 core_clk = ~core_clk;

    usifc_top #(.LVL_W(7)) i_usifc_top (
        .i_core_clk(core_clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_cts_n(cts_n), .i_dsr_n(dsr_n),
        .i_ri_n(ri_n), .i_cd_n(cd_n), .o_rts_n(rts_n), .o_dtr_n(dtr_n),
        .i_line_err(srcs[3]), .i_rx_timeout(srcs[2]), .i_rx_ready(srcs[1]),
        .i_tx_empty(srcs[0]), .i_rx_valid(rx_valid), .i_rx_char(rx_char),
        .i_xoff_seen(xoff_seen), .i_rx_level(rx_level), .o_irq(irq),
        .o_tx_halt(tx_halt), .o_sleep_en(sleep_en), .o_loopback(loopback),
        .o_sw_flow_sel(sw_flow_sel), .o_xon_any(xon_any), .o_fifo_en(fifo_en));

    usifc_peer i_usifc_peer (
        .i_core_clk(core_clk), .i_rst_n(rst_n), .i_assert(line_cmd),
        .o_cts_n(cts_n), .o_dsr_n(dsr_n), .o_ri_n(ri_n), .o_cd_n(cd_n));

    //////////////////////////////////////////////////////////////////////////
    // Verdict, reached from the main sequence or the watchdog
    task automatic close_out;
        $display("compares %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; master holds everything until pready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v,
                       output logic [31:0] rd, output logic er);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, v};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, v, rd, er);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 8'h00, rd, er);
        chk(rd, {24'h0, exp});
    endtask : rdc

    // Let edges pass, then look between edges where outputs are settled
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask : settle

    task automatic strobe(input logic [7:0] ch, input logic xo);
        @(posedge core_clk);
        rx_char   <= ch;
        rx_valid  <= ~xo;
        xoff_seen <= xo;
        @(posedge core_clk);
        rx_valid  <= 1'b0;
        xoff_seen <= 1'b0;
    endtask : strobe

    //////////////////////////////////////////////////////////////////////////
    // Watchdog: the sequence needs well under two thousand cycles
    always @(posedge core_clk) begin
        tick++;
        if (tick == 6000) begin
            err_total++;
            close_out();
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [5:0] codes [5] = '{6'h06, 6'h0C, 6'h04, 6'h02, 6'h00};
        logic [6:0] lv [5] = '{7'd12, 7'd8, 7'd4, 7'd8, 7'd11};
        logic       ex [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        settle(1);
        chk({irq, rts_n, dtr_n, tx_halt}, 4'b0110);
        rdc(OFS_MSR_LINE, 8'h00);
        rdc(OFS_IDENT, 8'h01);
        apb(1'b0, 8'h40, 8'h00, d, e);
        // Unmapped offset answers with an error and zero data
        chk({31'h0, e}, 32'h1);
        chk(d, 32'h0);
        // Enhanced bits locked, then unlocked
        wr(OFS_IER_SRC, 8'hFF);
        rdc(OFS_IER_SRC, 8'h0F);
        wr(OFS_EFR, 8'h1A);
        wr(OFS_IER_SRC, 8'h10);
        settle(1);
        chk({sleep_en, sw_flow_sel}, 5'h1A);
        wr(OFS_IDENT, 8'hFF);
        rdc(OFS_IDENT, 8'h01);
        // Each modem line in turn: level, delta, clear on read
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk) line_cmd[i] <= 1'b1;
            settle(6);
            apb(1'b0, OFS_MSR_LINE, 8'h00, d, e);
            chk(d[7:4], line_cmd);
            if (i != 2) chk(d[i], 1'b1);
            else ri0 = d[2];
            rdc(OFS_MSR_LINE, {line_cmd, 4'h0});
        end
        @(posedge core_clk) line_cmd <= 4'h0;
        settle(6);
        apb(1'b0, OFS_MSR_LINE, 8'h00, d, e);
        chk(ri0 ^ d[2], 1'b1);
        rdc(OFS_MSR_LINE, 8'h00);
        // Priority walk with a modem delta left pending
        wr(OFS_IER_SRC, 8'h0F);
        @(posedge core_clk) line_cmd[1] <= 1'b1;
        @(posedge core_clk) srcs <= 4'hF;
        for (int k = 0; k < 5; k++) begin
            settle(6);
            chk(irq, 1'b1);
            rdc(OFS_IDENT, {2'b00, codes[k]});
            if (k < 4) @(posedge core_clk) srcs[3-k] <= 1'b0;
        end
        rdc(OFS_MSR_LINE, 8'h22);
        rdc(OFS_IDENT, 8'h01);
        settle(2);
        chk(irq, 1'b0);
        // Single enables with every source raised
        @(posedge core_clk) srcs <= 4'hF;
        wr(OFS_IER_SRC, 8'h00);
        rdc(OFS_IDENT, 8'h01);
        for (int j = 0; j < 3; j++) begin
            wr(OFS_IER_SRC, 8'h01 << j);
            rdc(OFS_IDENT, {2'b00, j == 0 ? 6'h0C : (j == 1 ? 6'h02 : 6'h06)});
        end
        @(posedge core_clk) srcs <= 4'h0;
        wr(OFS_FCR, 8'h01);
        rdc(OFS_IDENT, 8'hC1);
        // Xoff and special character
        wr(OFS_IER_SRC, 8'h20);
        strobe(8'h00, 1'b1);
        rdc(OFS_IDENT, 8'hD0);
        rdc(OFS_IDENT, 8'hC1);
        wr(OFS_XOFF2, 8'h5A);
        wr(OFS_EFR, 8'h30);
        strobe(8'hA5, 1'b0);
        rdc(OFS_IDENT, 8'hC1);
        strobe(8'h5A, 1'b0);
        rdc(OFS_IDENT, 8'hD0);
        // CTS going inactive raises the lowest priority code
        wr(OFS_IER_SRC, 8'h80);
        @(posedge core_clk) line_cmd[0] <= 1'b1;
        settle(6);
        rdc(OFS_IDENT, 8'hC1);
        @(posedge core_clk) line_cmd[0] <= 1'b0;
        settle(6);
        rdc(OFS_IDENT, 8'hE0);
        rdc(OFS_IDENT, 8'hC1);
        // Auto-CTS halts while the peer holds CTS high
        wr(OFS_EFR, 8'h90);
        settle(2);
        chk(tx_halt, 1'b1);
        @(posedge core_clk) line_cmd[0] <= 1'b1;
        settle(6);
        chk(tx_halt, 1'b0);
        // Auto-RTS: halt at 12 bytes, restore at 4 bytes
        wr(OFS_MCR, 8'h40);
        wr(OFS_TCR, 8'h13);
        wr(OFS_EFR, 8'h50);
        for (int k = 0; k < 5; k++) begin
            @(posedge core_clk) rx_level <= lv[k];
            settle(3);
            chk(rts_n, ex[k]);
        end
        // Local loopback takes levels from the control bits
        wr(OFS_MCR, 8'h15);
        settle(4);
        apb(1'b0, OFS_MSR_LINE, 8'h00, d, e);
        chk({d[7:4], loopback, dtr_n}, 6'b0110_10);
        wr(OFS_MCR, 8'h37);
        rdc(OFS_MSR_LINE, 8'h71);
        // Still unlocked here, so the guarded control bit took the write
        chk(xon_any, 1'b1);
        chk(fifo_en, 1'b1);
        close_out();
    end
endmodule : tb
